/* File: hw/flash_fe_pkg.sv */
// Shared constants and types for the flash pin front end and its programmer.
// Assumes both ends run on one 100 MHz clock.
package flash_fe_pkg;
    localparam int ROW_W      = 11;
    localparam int COL_W_DEF  = 9;
    localparam int ID_W       = 4;
    localparam int GPI_W      = 5;
    localparam int CLK_MHZ    = 100;
    localparam int PROG_MAX_NS = 20000;
    localparam int PROG_CYC   = PROG_MAX_NS * CLK_MHZ / 1000;
    localparam int STAT_POLL_BIT   = 7;
    localparam int STAT_TOGGLE_BIT = 6;
    localparam int GPI_REG_ADDR    = 0;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    // Programmer register map
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_DATA   = 8'h08;
    localparam logic [7:0] REG_CMD    = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int CTRL_MODE    = 0;
    localparam int CTRL_RST     = 1;
    localparam int CTRL_INIT    = 2;
    localparam int CTRL_TGT_LSB = 4;
    localparam int CTRL_ID_LSB  = 8;
    localparam int CTRL_GPI_LSB = 12;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0006;
    localparam int CMD_GO   = 0;
    localparam int CMD_WR   = 1;
    localparam int CMD_REG  = 2;
    localparam int STAT_BUSY   = 0;
    localparam int STAT_RD_LSB = 8;
    localparam logic [3:0] PHASE_CYC  = 4'h4;
    localparam logic [3:0] STROBE_CYC = 4'h8;

    typedef enum logic [2:0] {
        SEQ_IDLE  = 3'b000,
        SEQ_ROW   = 3'b001,
        SEQ_COL   = 3'b011,
        SEQ_STRB  = 3'b010,
        SEQ_RLS   = 3'b110,
        SEQ_BREQ  = 3'b111,
        SEQ_BWAIT = 3'b101,
        SEQ_DONE  = 3'b100
    } seq_state_t;

    typedef enum logic {
        PROG_READY = 1'b0,
        PROG_BUSY  = 1'b1
    } prog_state_t;
endpackage : flash_fe_pkg

/* File: hw/flash_link_if.sv */
// Pin bundle between the flash front end and the programmer.
// The shared data byte resolves here; an undriven byte reads as pulled high.
`timescale 1ns/10ps
interface flash_link_if #(parameter int COL_W = flash_fe_pkg::COL_W_DEF);
    import flash_fe_pkg::*;
    logic                   mode_pp;
    logic                   reset_pin_n;
    logic                   init_pin_n;
    logic [ID_W-1:0]        strap_ident;
    logic [GPI_W-1:0]       board_inputs;
    logic [ROW_W-1:0]       muxed_addr_pins;
    logic                   row_sel;
    logic                   oe_pin_n;
    logic                   we_pin_n;
    logic [7:0]             dev_data_o;
    logic                   dev_data_oe;
    logic [7:0]             host_data_o;
    logic                   host_data_oe;
    logic [7:0]             byte_data_pins;
    logic                   bus_req;
    logic                   bus_write;
    logic                   bus_reg_space;
    logic [ID_W-1:0]        bus_target;
    logic [ROW_W+COL_W-1:0] bus_addr;
    logic                   bus_ack;

    assign byte_data_pins = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 8'hFF);

    modport device (
        input  mode_pp, reset_pin_n, init_pin_n, strap_ident, board_inputs,
        input  muxed_addr_pins, row_sel, oe_pin_n, we_pin_n, byte_data_pins,
        input  bus_req, bus_write, bus_reg_space, bus_target, bus_addr,
        output dev_data_o, dev_data_oe, bus_ack
    );
    modport programmer (
        output mode_pp, reset_pin_n, init_pin_n, strap_ident, board_inputs,
        output muxed_addr_pins, row_sel, oe_pin_n, we_pin_n, host_data_o, host_data_oe,
        output bus_req, bus_write, bus_reg_space, bus_target, bus_addr,
        input  byte_data_pins, bus_ack
    );
endinterface : flash_link_if

/* File: hw/flash_frontend.sv */
// Flash device pin front end: strap-selected parallel port or shared bus,
// address/data latching, program timing and status polling.
// Assumes every pin is asynchronous to clk_sys; all pass two flip-flops.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/10ps

module flash_frontend
    import flash_fe_pkg::*;
#(
    parameter int COL_W = COL_W_DEF
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Pins
    flash_link_if.device link,
    // Status
    output logic      prog_busy
);
    localparam int AW    = ROW_W + COL_W;
    localparam int DEPTH = 1 << AW;
    localparam int SW    = 3 + ID_W + GPI_W + ROW_W + 3 + 8 + 3 + ID_W + AW;

    // Column half shares the row pins, so it can be no wider than they are
    if (COL_W < 1 || COL_W > ROW_W) begin : g_col_check
        $error("COL_W out of range");
    end

    function automatic logic [AW-1:0] join_addr(input logic [COL_W-1:0] col, input logic [ROW_W-1:0] row);
        return {col, row};
    endfunction : join_addr

    // Two-flop synchronisers for every pin
    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;
    logic [SW-1:0] pin_raw;
    logic [SW-1:0] sync_rst;

    assign pin_raw = {link.mode_pp, link.reset_pin_n, link.init_pin_n, link.strap_ident,
                      link.board_inputs, link.muxed_addr_pins, link.row_sel, link.oe_pin_n,
                      link.we_pin_n, link.byte_data_pins, link.bus_req, link.bus_write,
                      link.bus_reg_space, link.bus_target, link.bus_addr};
    // Reset pins start asserted so the internal reset holds until their real level arrives
    assign sync_rst = {1'b0, 2'b00, {ID_W{1'b0}}, {GPI_W{1'b0}}, {ROW_W{1'b0}}, 1'b0, 2'b11,
                       8'h00, 3'b000, {ID_W{1'b0}}, {AW{1'b0}}};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync1_reg <= sync_rst;
            sync2_reg <= sync_rst;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
        end
    end

    logic             s_mode;
    logic             s_reset_n;
    logic             s_init_n;
    logic [ID_W-1:0]  s_ident;
    logic [GPI_W-1:0] s_gpi;
    logic [ROW_W-1:0] s_addr;
    logic             s_row_sel;
    logic             s_oe_n;
    logic             s_we_n;
    logic [7:0]       s_data;
    logic             s_req;
    logic             s_bwrite;
    logic             s_breg;
    logic [ID_W-1:0]  s_target;
    logic [AW-1:0]    s_baddr;

    assign {s_mode, s_reset_n, s_init_n, s_ident, s_gpi, s_addr, s_row_sel, s_oe_n, s_we_n,
            s_data, s_req, s_bwrite, s_breg, s_target, s_baddr} = sync2_reg;

    // Either reset pin gives the same internal reset
    logic rst_int;
    assign rst_int = !rst_n || !s_reset_n || !s_init_n;

    // Mode strap is sampled only while in reset, so a later change has no effect
    logic mode_pp_reg;
    always_ff @(posedge clk_sys) begin
        if (rst_int) begin
            mode_pp_reg <= s_mode;
        end
    end

    logic pp_on;
    logic bus_on;
    assign pp_on  = mode_pp_reg;
    assign bus_on = !mode_pp_reg;

    // Parallel port address halves
    logic [ROW_W-1:0] row_reg;
    logic [COL_W-1:0] col_reg;
    always_ff @(posedge clk_sys) begin
        if (rst_int) begin
            row_reg <= '0;
            col_reg <= '0;
        end else if (pp_on && s_we_n && s_oe_n) begin
            if (s_row_sel) begin
                row_reg <= s_addr;
            end else begin
                col_reg <= s_addr[COL_W-1:0];
            end
        end
    end

    // Strobe edges
    logic we_d_reg;
    logic oe_d_reg;
    logic we_fall;
    logic we_rise;
    logic oe_fall;
    always_ff @(posedge clk_sys) begin
        if (rst_int) begin
            we_d_reg <= 1'b1;
            oe_d_reg <= 1'b1;
        end else begin
            we_d_reg <= s_we_n;
            oe_d_reg <= s_oe_n;
        end
    end
    assign we_fall = pp_on && we_d_reg && !s_we_n;
    assign we_rise = pp_on && !we_d_reg && s_we_n;
    assign oe_fall = pp_on && oe_d_reg && !s_oe_n && s_we_n;

    // Bus access decode
    logic ack_reg;
    logic bus_hit;
    assign bus_hit = bus_on && s_req && !ack_reg && (s_target == s_ident);

    always_ff @(posedge clk_sys) begin
        if (rst_int) begin
            ack_reg <= 1'b0;
        end else if (bus_hit) begin
            ack_reg <= 1'b1;
        end else if (!s_req) begin
            ack_reg <= 1'b0;
        end
    end
    assign link.bus_ack = ack_reg;

    // Program engine
    prog_state_t      prog_state;
    logic [15:0]      prog_cnt_reg;
    logic [AW-1:0]    prog_addr_reg;
    logic [7:0]       prog_data_reg;
    logic             prog_start;
    logic [7:0]       mem [DEPTH];

    assign prog_start = (we_rise || (bus_hit && s_bwrite && !s_breg)) && prog_state == PROG_READY;

    always_ff @(posedge clk_sys) begin
        if (rst_int) begin
            prog_addr_reg <= '0;
        end else if (prog_state == PROG_READY) begin
            if (we_fall) begin
                prog_addr_reg <= join_addr(col_reg, row_reg);
            end else if (bus_hit && s_bwrite && !s_breg) begin
                prog_addr_reg <= s_baddr;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst_int) begin
            prog_data_reg <= ERASED_BYTE;
        end else if (prog_start) begin
            prog_data_reg <= s_data;
        end
    end

    // Fixed cycle count, never scaled by wear
    always_ff @(posedge clk_sys) begin
        if (rst_int) begin
            prog_state   <= PROG_READY;
            prog_cnt_reg <= '0;
        end else begin
            case (prog_state)
                PROG_READY: begin
                    prog_cnt_reg <= '0;
                    if (prog_start) begin
                        prog_state <= PROG_BUSY;
                    end
                end
                PROG_BUSY: begin
                    if (prog_cnt_reg == 16'(PROG_CYC - 1)) begin
                        prog_state <= PROG_READY;
                    end else begin
                        prog_cnt_reg <= prog_cnt_reg + 16'h0001;
                    end
                end
                default: prog_state <= PROG_READY;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (prog_state == PROG_BUSY && prog_cnt_reg == 16'(PROG_CYC - 1)) begin
            mem[prog_addr_reg] <= prog_data_reg;
        end
    end
    assign prog_busy = (prog_state == PROG_BUSY);

    // Status byte flips its toggle bit on every read while busy
    logic toggle_reg;
    logic read_start;
    logic [7:0] status_byte;
    assign read_start = oe_fall || (bus_hit && !s_bwrite && !s_breg);
    always_ff @(posedge clk_sys) begin
        if (rst_int || prog_state == PROG_READY) begin
            toggle_reg <= 1'b0;
        end else if (read_start) begin
            toggle_reg <= !toggle_reg;
        end
    end
    always_comb begin
        status_byte = 8'h00;
        status_byte[STAT_POLL_BIT]   = !prog_data_reg[STAT_POLL_BIT];
        status_byte[STAT_TOGGLE_BIT] = toggle_reg;
    end

    // Read data and driver enable
    logic [7:0] rd_reg;
    logic       drive_reg;
    always_ff @(posedge clk_sys) begin
        if (rst_int) begin
            rd_reg <= 8'h00;
        end else if (pp_on && !s_oe_n && s_we_n) begin
            rd_reg <= prog_busy ? status_byte : mem[join_addr(col_reg, row_reg)];
        end else if (bus_hit && !s_bwrite) begin
            if (s_breg) begin
                rd_reg <= (s_baddr == AW'(GPI_REG_ADDR)) ? {{(8-GPI_W){1'b0}}, s_gpi} : 8'h00;
            end else begin
                rd_reg <= prog_busy ? status_byte : mem[s_baddr];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst_int) begin
            drive_reg <= 1'b0;
        end else if (pp_on) begin
            drive_reg <= !s_oe_n && s_we_n;
        end else begin
            drive_reg <= (ack_reg || bus_hit) && !s_bwrite && s_req;
        end
    end
    assign link.dev_data_o  = rd_reg;
    assign link.dev_data_oe = drive_reg;
endmodule : flash_frontend

/* File: hw/flash_programmer.sv */
// Programmer / host end: APB register slave driving the flash pins.
// Assumes the device end samples every pin through two flip-flops.
`timescale 1ns/10ps
module flash_programmer
    import flash_fe_pkg::*;
#(
    parameter int COL_W = COL_W_DEF
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins
    flash_link_if.programmer link
);
    localparam int AW = ROW_W + COL_W;

    if (AW > 32 || COL_W < 1 || COL_W > ROW_W) begin : g_width_check
        $error("Address width not supported");
    end

    logic [31:0]   ctrl_reg;
    logic [AW-1:0] addr_reg;
    logic [7:0]    data_reg;
    logic          cmd_wr_reg;
    logic          cmd_reg_reg;
    logic [7:0]    rd_byte_reg;
    logic [31:0]   prdata_reg;
    logic          perr_reg;
    seq_state_t    state;
    logic [3:0]    cnt_reg;
    logic          busy;
    logic          setup;
    logic          wr_take;

    assign busy    = (state != SEQ_IDLE);
    assign setup   = psel && !penable;
    assign wr_take = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign prdata  = prdata_reg;
    assign pslverr = perr_reg;

    // Read data and error are prepared in the setup cycle, so no wait state
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prdata_reg <= 32'h0000_0000;
            perr_reg   <= 1'b0;
        end else if (setup) begin
            perr_reg   <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            if (paddr == REG_CTRL) begin
                prdata_reg <= ctrl_reg;
            end else if (paddr == REG_ADDR) begin
                prdata_reg <= 32'(addr_reg);
            end else if (paddr == REG_DATA) begin
                prdata_reg <= {24'h000000, data_reg};
            end else if (paddr == REG_CMD) begin
                prdata_reg <= {29'h0, cmd_reg_reg, cmd_wr_reg, 1'b0};
            end else if (paddr == REG_STATUS) begin
                prdata_reg <= {16'h0000, rd_byte_reg, 7'h00, busy};
            end else begin
                perr_reg <= 1'b1;
            end
        end
    end

    // Mode strap only moves while the device is held in reset; the ident strap moves on any write
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_take && paddr == REG_CTRL) begin
            ctrl_reg <= pwdata;
            if (!ctrl_reg[CTRL_RST]) begin
                ctrl_reg[CTRL_MODE] <= ctrl_reg[CTRL_MODE];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            addr_reg <= '0;
            data_reg <= 8'h00;
        end else if (wr_take && !busy) begin
            if (paddr == REG_ADDR) begin
                addr_reg <= pwdata[AW-1:0];
            end else if (paddr == REG_DATA) begin
                data_reg <= pwdata[7:0];
            end
        end
    end

    logic go;
    assign go = wr_take && paddr == REG_CMD && pwdata[CMD_GO] && !busy
                && !ctrl_reg[CTRL_RST] && !ctrl_reg[CTRL_INIT];

    // Pin inputs from the device
    logic [8:0] s1_reg;
    logic [8:0] s2_reg;
    logic [7:0] s_data;
    logic       s_ack;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1_reg <= 9'h000;
            s2_reg <= 9'h000;
        end else begin
            s1_reg <= {link.bus_ack, link.byte_data_pins};
            s2_reg <= s1_reg;
        end
    end
    assign {s_ack, s_data} = s2_reg;

    // Pin sequencer
    logic [ROW_W-1:0] pins_reg;
    logic row_sel_reg;
    logic oe_reg_n;
    logic we_reg_n;
    logic hdrv_reg;
    logic req_reg;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state       <= SEQ_IDLE;
            cnt_reg     <= 4'h0;
            cmd_wr_reg  <= 1'b0;
            cmd_reg_reg <= 1'b0;
            rd_byte_reg <= 8'h00;
            pins_reg    <= '0;
            row_sel_reg <= 1'b0;
            oe_reg_n    <= 1'b1;
            we_reg_n    <= 1'b1;
            hdrv_reg    <= 1'b0;
            req_reg     <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 4'h1;
            case (state)
                SEQ_IDLE: begin
                    cnt_reg <= 4'h0;
                    if (go) begin
                        cmd_wr_reg  <= pwdata[CMD_WR];
                        cmd_reg_reg <= pwdata[CMD_REG];
                        if (ctrl_reg[CTRL_MODE]) begin
                            state       <= SEQ_ROW;
                            pins_reg    <= addr_reg[ROW_W-1:0];
                            row_sel_reg <= 1'b1;
                        end else begin
                            state    <= SEQ_BREQ;
                            req_reg  <= 1'b1;
                            hdrv_reg <= pwdata[CMD_WR];
                        end
                    end
                end
                SEQ_ROW: if (cnt_reg == PHASE_CYC - 4'h1) begin
                    state       <= SEQ_COL;
                    cnt_reg     <= 4'h0;
                    pins_reg    <= ROW_W'(addr_reg[AW-1:ROW_W]);
                    row_sel_reg <= 1'b0;
                end
                SEQ_COL: if (cnt_reg == PHASE_CYC - 4'h1) begin
                    state    <= SEQ_STRB;
                    cnt_reg  <= 4'h0;
                    we_reg_n <= !cmd_wr_reg;
                    oe_reg_n <= cmd_wr_reg;
                    hdrv_reg <= cmd_wr_reg;
                end
                SEQ_STRB: if (cnt_reg == STROBE_CYC - 4'h1) begin
                    state    <= SEQ_RLS;
                    cnt_reg  <= 4'h0;
                    we_reg_n <= 1'b1;
                    oe_reg_n <= 1'b1;
                    if (!cmd_wr_reg) begin
                        rd_byte_reg <= s_data;
                    end
                end
                SEQ_RLS: if (cnt_reg == PHASE_CYC - 4'h1) begin
                    state    <= SEQ_DONE;
                    hdrv_reg <= 1'b0;
                end
                SEQ_BREQ: if (s_ack) begin
                    state   <= SEQ_BWAIT;
                    req_reg <= 1'b0;
                    if (!cmd_wr_reg) begin
                        rd_byte_reg <= s_data;
                    end
                end
                SEQ_BWAIT: if (!s_ack) begin
                    state    <= SEQ_DONE;
                    hdrv_reg <= 1'b0;
                end
                SEQ_DONE: state <= SEQ_IDLE;
                default: state <= SEQ_IDLE;
            endcase
        end
    end

    assign link.mode_pp         = ctrl_reg[CTRL_MODE];
    assign link.reset_pin_n     = !ctrl_reg[CTRL_RST];
    assign link.init_pin_n      = !ctrl_reg[CTRL_INIT];
    assign link.strap_ident     = ctrl_reg[CTRL_ID_LSB +: ID_W];
    assign link.board_inputs    = ctrl_reg[CTRL_GPI_LSB +: GPI_W];
    assign link.bus_target      = ctrl_reg[CTRL_TGT_LSB +: ID_W];
    assign link.muxed_addr_pins = pins_reg;
    assign link.row_sel         = row_sel_reg;
    assign link.oe_pin_n        = oe_reg_n;
    assign link.we_pin_n        = we_reg_n;
    assign link.host_data_o     = data_reg;
    assign link.host_data_oe    = hdrv_reg;
    assign link.bus_req         = req_reg;
    assign link.bus_write       = cmd_wr_reg;
    assign link.bus_reg_space   = cmd_reg_reg;
    assign link.bus_addr        = addr_reg;
endmodule : flash_programmer

/* File: testbench/flash_link_chk.sv */
// Assertions on the link that joins the flash front end and the programmer.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module flash_link_chk (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_n,
    // Link
    input wire logic       mode_pp,
    input wire logic       reset_pin_n,
    input wire logic       init_pin_n,
    input wire logic       oe_pin_n,
    input wire logic       dev_data_oe,
    input wire logic       bus_req,
    input wire logic       bus_ack,
    input wire logic [3:0] bus_target,
    input wire logic [3:0] strap_ident
);
    logic live;
    // Pins pass two sync stages, so every window below allows three cycles of lag
    assign live = reset_pin_n && init_pin_n;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_gate_off: assert property ((mode_pp && oe_pin_n)[*4] |-> !dev_data_oe)
        else $error("data driven with gate high");
    a_read_drive: assert property (live && mode_pp && $fell(oe_pin_n) |-> ##[2:4] dev_data_oe)
        else $error("no read drive");
    a_pp_no_ack: assert property (mode_pp[*4] |-> !bus_ack)
        else $error("bus answered in parallel mode");
    a_drive_acked: assert property (!mode_pp && dev_data_oe |-> bus_ack)
        else $error("bus drive without ack");
    a_ident_ack: assert property ($rose(bus_ack) |-> bus_target == strap_ident)
        else $error("ack for foreign ident");
    a_ack_timely: assert property (live && !mode_pp && $rose(bus_req) && bus_target == strap_ident
        |-> ##[1:5] bus_ack)
        else $error("ack missing");
    a_ack_hold: assert property (bus_ack && bus_req |=> bus_ack)
        else $error("ack dropped early");
    a_ack_release: assert property ($fell(bus_req) |-> ##[1:5] !bus_ack)
        else $error("ack stuck");
endmodule : flash_link_chk

/* File: testbench/flash_pin_interface_frontend_tb.sv */
// Bench for the flash front end and its programmer joined by the link.
// Assumes APB access to the programmer and default parameters.
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module flash_pin_interface_frontend_tb;
    import flash_fe_pkg::*;
    logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, prog_busy, tgl;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rv;
    int          n_mismatch, total_checks, cyc, run, last_run;
    flash_link_if link ();
    flash_frontend flash_frontend_inst (.clk_sys, .rst_n, .link(link), .prog_busy);
    flash_programmer flash_programmer_inst (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .link(link));
    flash_link_chk flash_link_chk_inst (.clk_sys, .rst_n, .mode_pp(link.mode_pp),
        .reset_pin_n(link.reset_pin_n), .init_pin_n(link.init_pin_n), .oe_pin_n(link.oe_pin_n),
        .dev_data_oe(link.dev_data_oe), .bus_req(link.bus_req), .bus_ack(link.bus_ack),
        .bus_target(link.bus_target), .strap_ident(link.strap_ident));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Program length is measured here so polling jitter never enters it
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        run <= prog_busy ? run + 1 : 0;
        if (!prog_busy && run != 0) last_run <= run;
        if (cyc == 40000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : stop_test
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_idle;
        do apb(1'b0, REG_STATUS, 32'h0); while (rv[STAT_BUSY] !== 1'b0);
    endtask : wait_idle
    task automatic op(input logic [31:0] a, input logic [7:0] d, input logic [31:0] c);
        apb(1'b1, REG_ADDR, a);
        apb(1'b1, REG_DATA, {24'h0, d});
        apb(1'b1, REG_CMD, c);
        wait_idle();
    endtask : op
    task automatic wait_prog;
        while (prog_busy !== 1'b0) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
    endtask : wait_prog
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rst_n = 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0);
        `CHK(rv, CTRL_RESET)
        apb(1'b0, 8'h40, 32'h0);
        `CHK(pslverr, 1'b1)
        $display("regs done");
        apb(1'b1, REG_CTRL, 32'h7);
        apb(1'b1, REG_CTRL, 32'h1);
        op(32'h54321, 8'h3C, 32'h3);
        op(32'h54321, 8'h00, 32'h1);
        `CHK(rv[15:8] & 8'hBF, 8'h80)
        tgl = rv[14];
        op(32'h54321, 8'h00, 32'h1);
        `CHK(rv[14], ~tgl)
        wait_prog();
        `CHK(last_run, PROG_CYC)
        // Same row, address bit 11 (column bit 0) flipped
        op(32'h54B21, 8'hA5, 32'h3);
        wait_prog();
        `CHK(last_run, PROG_CYC)
        op(32'h54321, 8'h00, 32'h1);
        `CHK(rv[15:8], 8'h3C)
        op(32'h54B21, 8'h00, 32'h1);
        `CHK(rv[15:8], 8'hA5)
        $display("parallel done");
        op(32'h00100, 8'h11, 32'h3);
        `CHK(prog_busy, 1'b1)
        apb(1'b1, REG_CTRL, 32'h5);
        repeat (5) @(posedge clk_sys);
        `CHK(prog_busy, 1'b0)
        apb(1'b1, REG_CTRL, 32'h1);
        repeat (5) @(posedge clk_sys);
        op(32'h00100, 8'h22, 32'h3);
        apb(1'b1, REG_CTRL, 32'h3);
        repeat (5) @(posedge clk_sys);
        `CHK(prog_busy, 1'b0)
        $display("reset pins done");
        apb(1'b1, REG_CTRL, 32'h15006);
        apb(1'b1, REG_CTRL, 32'h15000);
        repeat (5) @(posedge clk_sys);
        op(GPI_REG_ADDR, 8'h00, 32'h5);
        `CHK(rv[15:8], 8'h15)
        op(32'h1, 8'h55, 32'h7);
        `CHK(prog_busy, 1'b0)
        op(32'h1, 8'h00, 32'h5);
        `CHK(rv[15:8], 8'h00)
        op(32'h00200, 8'h96, 32'h3);
        wait_prog();
        `CHK(last_run, PROG_CYC)
        op(32'h00200, 8'h00, 32'h1);
        `CHK(rv[15:8], 8'h96)
        $display("bus done");
        // Foreign target never gets an answer, so the host stays busy
        apb(1'b1, REG_CTRL, 32'h15020);
        apb(1'b1, REG_CMD, 32'h5);
        repeat (60) @(posedge clk_sys);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK(rv[STAT_BUSY], 1'b1)
        $display("foreign ident done");
        stop_test();
    end
endmodule : flash_pin_interface_frontend_tb
